// >>> hio_glue.sv
/*
  Host I/O decode and line sync glue: joins the PC expansion bus to
  the network controller. Decodes the fixed register window and the
  remote DMA data port, makes the port acknowledges and the wait
  signal, selects the address PROM and passes reset and memory write.
  Assumes host strobes and addresses synchronous to clk_in; the host
  bus wires the wait pin from its value and enable.
*/
`timescale 1ns/1ps
`include "hio_params.svh"

// Summary of operation
// - I/O window fixed at base 300h
// - Chip select for addresses 300h through 30fh
// - Data port decoded at 310h through 31fh
// - Chip select needs active read or write strobe
// - Wait while controller busy during register access
// - Controller acknowledge ends register wait states
// - Port read waits until port request rises
// - Port write waits until port request rises
// - Read and write acknowledges end one transfer
// - Acks from DMA acknowledge or decoded port
// - Wait pin driven only during decoded accesses
// - PROM select on low bit13 with read
// - Line inputs registered on inverted 20 MHz
// - Stage two carrier sense combines stage one
// - Controller reset is inverted host reset
// - Memory write passes straight through
// - Offset zero command, pages behind offsets 1-15
module hio_glue (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire hio_pkg::hio_io_addr_t host_addr_in,
  input wire logic host_aen_in,
  input wire logic host_ior_n_in,
  input wire logic host_iow_n_in,
  input wire logic host_dack_n_in,
  input wire logic host_reset_in,
  input wire logic port_transfer_request_in,
  input wire logic ctrl_ack_n_in,
  input wire logic local_address_bit13_in,
  input wire logic local_memory_read_n_in,
  input wire logic memory_write_n_in,
  input wire logic raw_carrier_sense_in,
  input wire logic collision_in,
  output logic controller_chip_select_n_out,
  output logic [3:0] controller_reg_offset_out,
  output logic command_reg_select_out,
  output logic remote_read_ack_n_out,
  output logic remote_write_ack_n_out,
  output logic wait_drive_enable_out,
  output logic io_channel_ready_out,
  output logic io_channel_ready_oe_out,
  output logic address_prom_select_n_out,
  output logic controller_reset_n_out,
  output logic memory_write_n_out,
  output logic inverted_bus_clock_out,
  output logic carrier_sense_stage1_out,
  output logic carrier_sense_stage2_out,
  output logic collision_registered_out
);
  import hio_pkg::*;

  hio_glue_state_t state_q;
  hio_glue_state_t state_d;
  hio_access_t access;
  logic rst_ok;
  logic ior;
  logic iow;
  logic strobe;
  logic dack;
  logic ack;
  logic port_transfer_request;
  logic reg_sel;
  logic port_sel;
  logic port_rd;
  logic port_wr;
  logic remote_read_ack;
  logic remote_write_ack;
  logic wait_drive_enable;
  logic wait_reg;
  logic wait_port;
  logic wait_req;

  assign rst_ok = state_q.rst_sync;
  assign ior = ~host_ior_n_in;
  assign iow = ~host_iow_n_in;
  assign strobe = ior | iow;
  assign dack = ~host_dack_n_in;
  assign ack = ~ctrl_ack_n_in;
  assign port_transfer_request = port_transfer_request_in;

  // Base compare is a constant; there is deliberately no override
  assign access = hio_classify(host_addr_in, host_aen_in);

  always_comb
  begin
    reg_sel = 1'b0;
    port_sel = 1'b0;
    case (access)
      hio_acc_reg:
      begin
        reg_sel = strobe & rst_ok;
      end
      hio_acc_port:
      begin
        port_sel = strobe & rst_ok;
      end
      default:
      begin
        reg_sel = 1'b0;
        port_sel = 1'b0;
      end
    endcase
  end

  assign port_rd = port_sel & ior;
  assign port_wr = port_sel & iow;

  // The DMA term carries no address, so address enable does not gate it
  assign remote_read_ack = rst_ok & ((port_rd & port_transfer_request) | (dack & ior));
  assign remote_write_ack = rst_ok & ((port_wr & port_transfer_request) | (dack & iow));

  assign wait_drive_enable = reg_sel | port_sel;

  // Once ack or request has been seen the cycle stays released, so a
  // controller that drops its line early cannot stretch the host cycle
  assign wait_reg = reg_sel & ~ack & ~state_q.reg_ack_seen;
  assign wait_port = port_sel & ~port_transfer_request & ~state_q.prq_seen;
  assign wait_req = wait_reg | wait_port;

  always_comb
  begin
    state_d = state_q;
    state_d.rst_meta = 1'b1;
    state_d.rst_sync = state_q.rst_meta;
    // Set wins: a strobe holding while ack arrives keeps the flag
    if (reg_sel & ack)
    begin
      state_d.reg_ack_seen = 1'b1;
    end
    else if (!reg_sel)
    begin
      state_d.reg_ack_seen = 1'b0;
    end
    if (port_sel & port_transfer_request)
    begin
      state_d.prq_seen = 1'b1;
    end
    else if (!port_sel)
    begin
      state_d.prq_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q <= '{rst_meta: `HIO_RST_SYNC_INIT,
                   rst_sync: `HIO_RST_SYNC_INIT,
                   reg_ack_seen: `HIO_FLAG_INIT,
                   prq_seen: `HIO_FLAG_INIT};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign controller_chip_select_n_out = ~reg_sel;
  assign controller_reg_offset_out =
    host_addr_in[`HIO_OFFSET_MSB:0];
  // Page bits inside the controller pick what offsets 1-15 mean
  assign command_reg_select_out = reg_sel &
    (host_addr_in[`HIO_OFFSET_MSB:0] == `HIO_CMD_OFFSET);
  assign remote_read_ack_n_out = ~remote_read_ack;
  assign remote_write_ack_n_out = ~remote_write_ack;
  assign wait_drive_enable_out = wait_drive_enable;
  // Pin is driven high when released, low to insert wait states
  assign io_channel_ready_out = ~wait_req;
  assign io_channel_ready_oe_out = wait_drive_enable;
  // PROM is reached only on the controller's local bus
  assign address_prom_select_n_out =
    ~(rst_ok & ~local_address_bit13_in & ~local_memory_read_n_in);
  // Pass-throughs stay live during our own reset on purpose
  assign controller_reset_n_out = ~host_reset_in;
  assign memory_write_n_out = memory_write_n_in;

  hio_line_sync u_line_sync (
    .clk_in(clk_in),
    .rst_n_in(state_q.rst_sync),
    .raw_carrier_sense_in(raw_carrier_sense_in),
    .collision_in(collision_in),
    .inverted_bus_clock_out(inverted_bus_clock_out),
    .carrier_sense_stage1_out(carrier_sense_stage1_out),
    .carrier_sense_stage2_out(carrier_sense_stage2_out),
    .collision_registered_out(collision_registered_out)
  );

  // Checks on the bus-facing decode
  logic chk_reg_addr;
  logic chk_port_addr;
  assign chk_reg_addr = (hio_classify(host_addr_in, host_aen_in) ==
                         hio_acc_reg);
  assign chk_port_addr = (hio_classify(host_addr_in, host_aen_in) ==
                          hio_acc_port);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!state_q.rst_sync);

  cs_base_fixed_a: assert property (
    !controller_chip_select_n_out |->
      host_addr_in[9:4] == 6'h30)
    else $error("chip select outside fixed base");
  cs_window_a: assert property (
    (!host_aen_in && host_addr_in >= 10'h300 && host_addr_in <= 10'h30f
     && (!host_ior_n_in || !host_iow_n_in))
      |-> !controller_chip_select_n_out)
    else $error("register window access not selected");
  port_decode_a: assert property (
    (!host_aen_in && host_addr_in == 10'h310 && !host_ior_n_in &&
     port_transfer_request_in) |-> !remote_read_ack_n_out)
    else $error("data port read not acknowledged");
  cs_strobe_a: assert property (
    (host_ior_n_in && host_iow_n_in) |-> controller_chip_select_n_out)
    else $error("chip select without strobe");
  reg_wait_a: assert property (
    (chk_reg_addr && !host_ior_n_in && ctrl_ack_n_in &&
     $past(host_ior_n_in)) |->
      io_channel_ready_oe_out && !io_channel_ready_out)
    else $error("busy register access did not wait");
  ack_release_a: assert property (
    (!controller_chip_select_n_out && !ctrl_ack_n_in) ##1
      !controller_chip_select_n_out |-> io_channel_ready_out)
    else $error("wait held after controller acknowledge");
  port_rd_wait_a: assert property (
    (chk_port_addr && !host_ior_n_in && $past(host_ior_n_in) &&
     !port_transfer_request_in) |-> !io_channel_ready_out)
    else $error("early port read did not wait");
  port_wr_wait_a: assert property (
    (chk_port_addr && !host_iow_n_in && $past(host_iow_n_in) &&
     !port_transfer_request_in) |-> !io_channel_ready_out)
    else $error("early port write did not wait");
  port_wr_ack_a: assert property (
    (chk_port_addr && !host_iow_n_in && port_transfer_request_in)
      |-> !remote_write_ack_n_out && remote_read_ack_n_out)
    else $error("port write acknowledge wrong");
  dma_ack_a: assert property (
    (!host_dack_n_in && !host_ior_n_in && host_iow_n_in) |->
      !remote_read_ack_n_out && remote_write_ack_n_out)
    else $error("DMA read acknowledge missing");
  no_ack_idle_a: assert property (
    (host_dack_n_in && !port_transfer_request_in) |->
      remote_read_ack_n_out && remote_write_ack_n_out)
    else $error("acknowledge without DMA or request");
  wait_hiz_a: assert property (
    !(chk_reg_addr || chk_port_addr) || (host_ior_n_in && host_iow_n_in)
      |-> !io_channel_ready_oe_out)
    else $error("wait pin driven outside decode");
  prom_sel_a: assert property (
    address_prom_select_n_out ==
      (local_address_bit13_in || local_memory_read_n_in))
    else $error("PROM select wrong");
  aen_block_a: assert property (
    host_aen_in |-> controller_chip_select_n_out &&
                    !io_channel_ready_oe_out)
    else $error("decode during address enable");
  cmd_offset_a: assert property (
    command_reg_select_out |->
      !controller_chip_select_n_out && host_addr_in[3:0] == 4'h0)
    else $error("command register select wrong");
  port_release_a: assert property (
    (chk_port_addr && !host_ior_n_in && port_transfer_request_in) ##1
      (chk_port_addr && !host_ior_n_in) |-> io_channel_ready_out)
    else $error("port wait after request");

  reg_wait_cov: cover property (
    (!controller_chip_select_n_out && !io_channel_ready_out) ##[1:20]
      (!controller_chip_select_n_out && io_channel_ready_out));
  port_read_cov: cover property (
    (chk_port_addr && !host_ior_n_in && !io_channel_ready_out)
      ##[1:20] !remote_read_ack_n_out);
  dma_write_cov: cover property (
    !host_dack_n_in && !host_iow_n_in && !remote_write_ack_n_out);
  prom_read_cov: cover property (!address_prom_select_n_out);

endmodule : hio_glue

// >>> hio_host_model.sv
/*
  Host bus model: drives I/O and DMA cycles into the glue and resolves
  the wait pin. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps

module hio_host_model (
  input wire logic clk_in,
  input wire logic io_channel_ready_in,
  input wire logic io_channel_ready_oe_in,
  output hio_pkg::hio_io_addr_t host_addr_out,
  output logic host_aen_out,
  output logic host_ior_n_out,
  output logic host_iow_n_out,
  output logic host_dack_n_out,
  output logic ready_pin_out,
  output logic stuck_out
);
  import hio_pkg::*;

  // The pin has a pull-up, so a released pin reads high
  assign ready_pin_out = io_channel_ready_oe_in ? io_channel_ready_in : 1'h1;

  initial
  begin
    host_addr_out = 10'h000;
    host_aen_out = 1'h0;
    host_ior_n_out = 1'h1;
    host_iow_n_out = 1'h1;
    host_dack_n_out = 1'h1;
    stuck_out = 1'h0;
  end

  // Address settles in the same edge as the strobe
  task automatic io_begin(input hio_io_addr_t addr, input logic wr,
                          input logic aen);
    @(posedge clk_in);
    host_addr_out <= addr;
    host_aen_out <= aen;
    host_ior_n_out <= wr;
    host_iow_n_out <= ~wr;
  endtask : io_begin

  // No direct host path to the PROM: its bytes come through the remote
  // DMA port like any other buffer data
  // DMA cycles raise address enable with the acknowledge
  task automatic dma_begin(input logic wr);
    @(posedge clk_in);
    host_addr_out <= 10'h305;
    host_aen_out <= 1'h1;
    host_dack_n_out <= 1'h0;
    host_ior_n_out <= wr;
    host_iow_n_out <= ~wr;
  endtask : dma_begin

  // Strobe held until the pin reads ready at a rising edge, bounded
  task automatic cycle_end();
    int n;
    n = 0;
    @(posedge clk_in);
    while (ready_pin_out !== 1'h1 && n < 64)
    begin
      n++;
      @(posedge clk_in);
    end
    if (n >= 64)
      stuck_out <= 1'h1;
    host_ior_n_out <= 1'h1;
    host_iow_n_out <= 1'h1;
    host_dack_n_out <= 1'h1;
    host_aen_out <= 1'h0;
  endtask : cycle_end
endmodule : hio_host_model

// >>> hio_line_sync.sv
/*
  Line sync: derives the 20 MHz bus clock from the 200 MHz clock and
  samples carrier sense and collision on its inverted rising edge.
  Assumes a reset that is already synchronous to clk_in.
*/
`timescale 1ns/1ps
`include "hio_params.svh"

module hio_line_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic raw_carrier_sense_in,
  input wire logic collision_in,
  output logic inverted_bus_clock_out,
  output logic carrier_sense_stage1_out,
  output logic carrier_sense_stage2_out,
  output logic collision_registered_out
);
  import hio_pkg::*;

  localparam logic [3:0] DIV_LAST = 4'(`HIO_DIV_RATIO - 1);
  localparam logic [3:0] DIV_HALF = 4'(`HIO_DIV_HALF);

  hio_sync_state_t state_q;
  hio_sync_state_t state_d;
  logic sample;

  // Inverted bus clock rises as the bus clock falls
  assign sample = (state_q.div_cnt == DIV_HALF - 4'h1);

  always_comb
  begin
    state_d = state_q;
    state_d.div_cnt = (state_q.div_cnt == DIV_LAST) ? 4'h0 :
                      state_q.div_cnt + 4'h1;
    state_d.bus_clk = (state_d.div_cnt < DIV_HALF);
    if (sample)
    begin
      state_d.carrier_sense_stage1 = raw_carrier_sense_in;
      // Low-true OR of stage 1 and raw input, i.e. both must be high
      state_d.carrier_sense_stage2 = state_q.carrier_sense_stage1 & raw_carrier_sense_in;
      state_d.collision_registered = collision_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= '{div_cnt: `HIO_DIV_INIT, bus_clk: `HIO_BUS_CLK_INIT,
                   carrier_sense_stage1: `HIO_LINE_INIT, carrier_sense_stage2: `HIO_LINE_INIT,
                   collision_registered: `HIO_LINE_INIT};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign inverted_bus_clock_out = ~state_q.bus_clk;
  // Only registered copies leave, so no half level reaches the controller
  assign carrier_sense_stage1_out = state_q.carrier_sense_stage1;
  assign carrier_sense_stage2_out = state_q.carrier_sense_stage2;
  assign collision_registered_out = state_q.collision_registered;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  crs_stage1_a: assert property (
    sample |=> carrier_sense_stage1_out == $past(raw_carrier_sense_in))
    else $error("stage 1 carrier sense missed its sample");
  crs_hold_a: assert property (
    !sample |=> $stable(carrier_sense_stage1_out) &&
                $stable(collision_registered_out))
    else $error("line register changed off the sample edge");
  crs_stage2_a: assert property (
    sample |=> carrier_sense_stage2_out ==
      ($past(carrier_sense_stage1_out) & $past(raw_carrier_sense_in)))
    else $error("stage 2 carrier sense wrong");
  // Next rise exactly ten fast cycles later: nine quiet cycles, then a rise
  bus_clk_rate_a: assert property (
    $rose(inverted_bus_clock_out) |=>
      (!$rose(inverted_bus_clock_out))[*8] ##1
      !$rose(inverted_bus_clock_out) ##1 $rose(inverted_bus_clock_out))
    else $error("bus clock period wrong");

endmodule : hio_line_sync

// >>> hio_params.svh
/*
  Constants for the host I/O decode and line sync glue: fixed I/O
  window, field positions, clock rates and reset values.
  Assumes it is included by bare name from the package and modules.
*/
`ifndef HIO_PARAMS_SVH
`define HIO_PARAMS_SVH

// Fixed I/O window; no strap or jumper moves it
`define HIO_IO_BASE 10'h300
`define HIO_PORT_ADDR 10'h310
`define HIO_WINDOW_MSB 9
`define HIO_WINDOW_LSB 4
`define HIO_OFFSET_MSB 3
`define HIO_CMD_OFFSET 4'h0

// Timing
`define HIO_CLK_PERIOD_PS 5000
`define HIO_BUS_CLK_PERIOD_PS 50000
`define HIO_DIV_RATIO (`HIO_BUS_CLK_PERIOD_PS / `HIO_CLK_PERIOD_PS)
`define HIO_DIV_HALF (`HIO_DIV_RATIO / 2)

// Reset values
`define HIO_RST_SYNC_INIT 1'h0
`define HIO_FLAG_INIT 1'h0
`define HIO_DIV_INIT 4'h0
`define HIO_BUS_CLK_INIT 1'h1
`define HIO_LINE_INIT 1'h0

`endif

// >>> hio_pkg.sv
/*
  Types and the shared address classifier for the host I/O glue.
  Assumes hio_params.svh is on the include path.
*/
`include "hio_params.svh"

package hio_pkg;

  typedef logic [9:0] hio_io_addr_t;

  typedef enum logic [1:0] {
    hio_acc_none,
    hio_acc_reg,
    hio_acc_port
  } hio_access_t;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic reg_ack_seen;
    logic prq_seen;
  } hio_glue_state_t;

  typedef struct packed {
    logic [3:0] div_cnt;
    logic bus_clk;
    logic carrier_sense_stage1;
    logic carrier_sense_stage2;
    logic collision_registered;
  } hio_sync_state_t;

  localparam hio_io_addr_t HIO_BASE = `HIO_IO_BASE;
  localparam hio_io_addr_t HIO_PORT = `HIO_PORT_ADDR;

  // Address enable high marks a DMA address cycle: nothing decodes then
  function automatic hio_access_t hio_classify(
    input hio_io_addr_t addr,
    input logic aen
  );
    hio_access_t kind;
    kind = hio_acc_none;
    if (aen)
    begin
      kind = hio_acc_none;
    end
    else if (addr[`HIO_WINDOW_MSB:`HIO_WINDOW_LSB] ==
             HIO_BASE[`HIO_WINDOW_MSB:`HIO_WINDOW_LSB])
    begin
      kind = hio_acc_reg;
    end
    else if (addr[`HIO_WINDOW_MSB:`HIO_WINDOW_LSB] ==
             HIO_PORT[`HIO_WINDOW_MSB:`HIO_WINDOW_LSB])
    begin
      kind = hio_acc_port;
    end
    return kind;
  endfunction : hio_classify

endpackage : hio_pkg

// >>> host_io_decode_and_line_sync_glue_tb_top.sv
/*
  Self-checking bench for the host I/O glue: decode, wait, acks, PROM
  select, pass-throughs and line sync. Assumes hio_pkg is compiled.
*/
`timescale 1ns/1ps

module host_io_decode_and_line_sync_glue_tb_top;
  import hio_pkg::*;

  logic clk, arst_n, ack_n, port_transfer_request, bit13, lmrd_n, mw_n, hrst, raw_carrier_sense, col;
  logic cs_n, cmd, remote_read_ack_n, remote_write_ack_n, wde, rdy, oe, prom_n, crst_n, mwo_n;
  logic ibc, cs1, cs2, collision_registered, aen, ior_n, iow_n, dack_n, pin, stuck;
  logic [3:0] off;
  hio_io_addr_t addr;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  hio_glue DUT (.clk_in(clk), .arst_n_in(arst_n), .host_addr_in(addr),
    .host_aen_in(aen), .host_ior_n_in(ior_n), .host_iow_n_in(iow_n),
    .host_dack_n_in(dack_n), .host_reset_in(hrst),
    .port_transfer_request_in(port_transfer_request), .ctrl_ack_n_in(ack_n),
    .local_address_bit13_in(bit13), .local_memory_read_n_in(lmrd_n),
    .memory_write_n_in(mw_n), .raw_carrier_sense_in(raw_carrier_sense),
    .collision_in(col), .controller_chip_select_n_out(cs_n),
    .controller_reg_offset_out(off), .command_reg_select_out(cmd),
    .remote_read_ack_n_out(remote_read_ack_n), .remote_write_ack_n_out(remote_write_ack_n),
    .wait_drive_enable_out(wde), .io_channel_ready_out(rdy),
    .io_channel_ready_oe_out(oe), .address_prom_select_n_out(prom_n),
    .controller_reset_n_out(crst_n), .memory_write_n_out(mwo_n),
    .inverted_bus_clock_out(ibc), .carrier_sense_stage1_out(cs1),
    .carrier_sense_stage2_out(cs2), .collision_registered_out(collision_registered));

  hio_host_model host (.clk_in(clk), .io_channel_ready_in(rdy),
    .io_channel_ready_oe_in(oe), .host_addr_out(addr),
    .host_aen_out(aen), .host_ior_n_out(ior_n), .host_iow_n_out(iow_n),
    .host_dack_n_out(dack_n), .ready_pin_out(pin), .stuck_out(stuck));

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Bound well above the fewer than 200 cycles the scenarios need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk1(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk1

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t offset got %h exp %h", $time, got, exp);
    end
  endtask : chk4

  task automatic t_reg_window();
    for (int i = 0; i < 16; i++)
    begin
      host.io_begin(10'h300 + 10'(i), i[0], 1'h0);
      @(negedge clk);
      chk1(cs_n, 1'h0, "cs");
      chk4(off, 4'(i));
      chk1(cmd, i == 0, "cmd");
      chk1(oe & wde, 1'h1, "oe");
      chk1(pin, 1'h1, "rdy");
      host.cycle_end();
    end
    host.io_begin(10'h2ff, 1'h0, 1'h0);
    @(negedge clk);
    chk1(cs_n & ~oe, 1'h1, "2ff");
    host.cycle_end();
  endtask : t_reg_window

  task automatic t_reg_wait(input logic wr);
    @(posedge clk);
    ack_n <= 1'h1;
    host.io_begin(10'h305, wr, 1'h0);
    repeat (3)
    begin
      @(negedge clk);
      chk1(pin, 1'h0, "busy wait");
    end
    @(posedge clk);
    ack_n <= 1'h0;
    @(negedge clk);
    chk1(pin, 1'h1, "ack release");
    @(posedge clk);
    ack_n <= 1'h1;
    @(negedge clk);
    chk1(pin, 1'h1, "ack hold");
    host.cycle_end();
    @(negedge clk);
    chk1(cs_n & ~oe, 1'h1, "idle");
  endtask : t_reg_wait

  task automatic t_port(input logic wr);
    @(posedge clk);
    port_transfer_request <= 1'h0;
    host.io_begin(10'h310, wr, 1'h0);
    repeat (2)
    begin
      @(negedge clk);
      chk1(pin, 1'h0, "port wait");
      chk1(oe & cs_n & remote_read_ack_n & remote_write_ack_n, 1'h1, "port");
    end
    @(posedge clk);
    port_transfer_request <= 1'h1;
    @(negedge clk);
    chk1(pin, 1'h1, "port go");
    chk1(remote_read_ack_n, wr, "remote_read_ack");
    chk1(remote_write_ack_n, ~wr, "remote_write_ack");
    // Request drops while the strobe still stands: no new wait
    @(posedge clk);
    port_transfer_request <= 1'h0;
    @(negedge clk);
    chk1(pin, 1'h1, "port hold");
    chk1(remote_read_ack_n & remote_write_ack_n, 1'h1, "ack drop");
    host.cycle_end();
    @(negedge clk);
    chk1(remote_read_ack_n & remote_write_ack_n & ~oe, 1'h1, "port end");
  endtask : t_port

  task automatic t_aen_dma(input logic wr);
    @(posedge clk);
    port_transfer_request <= 1'h1;
    host.io_begin(wr ? 10'h300 : 10'h310, wr, 1'h1);
    @(negedge clk);
    chk1(cs_n & remote_read_ack_n & remote_write_ack_n & ~oe, 1'h1, "aen");
    host.cycle_end();
    host.dma_begin(wr);
    @(negedge clk);
    chk1(remote_read_ack_n, wr, "dma remote_read_ack");
    chk1(remote_write_ack_n, ~wr, "dma remote_write_ack");
    chk1(cs_n & ~oe, 1'h1, "dma");
    host.cycle_end();
  endtask : t_aen_dma

  task automatic t_prom_pass();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      {bit13, lmrd_n} <= 2'(i);
      {hrst, mw_n} <= 2'(i);
      @(negedge clk);
      chk1(prom_n, i[1] | i[0], "prom");
      chk1(crst_n, ~i[1], "nic reset");
      chk1(mwo_n, i[0], "mwr");
    end
  endtask : t_prom_pass

  task automatic wait_ibc(input logic v, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (ibc !== v && n < 40);
  endtask : wait_ibc

  task automatic t_line();
    int a;
    int b;
    wait_ibc(1'h0, a);
    wait_ibc(1'h1, a);
    wait_ibc(1'h0, a);
    wait_ibc(1'h1, b);
    chk1(a + b == 10, 1'h1, "bus clock");
    @(posedge clk);
    raw_carrier_sense <= 1'h1;
    col <= 1'h1;
    repeat (3) @(negedge clk);
    chk1(cs1 | collision_registered, 1'h0, "raw seen");
    a = 0;
    while (cs1 !== 1'h1 && a < 20)
    begin
      @(negedge clk);
      a++;
    end
    chk1(collision_registered, 1'h1, "col");
    chk1(cs2, 1'h0, "carrier_sense_stage2 first");
    repeat (11) @(negedge clk);
    chk1(cs2 & cs1, 1'h1, "carrier_sense_stage2");
    @(posedge clk);
    raw_carrier_sense <= 1'h0;
    col <= 1'h0;
    repeat (22) @(negedge clk);
    chk1(cs1 | cs2 | collision_registered, 1'h0, "crs low");
  endtask : t_line

  initial
  begin
    {arst_n, port_transfer_request, bit13, lmrd_n, mw_n, hrst, raw_carrier_sense, col} = 8'h1c;
    ack_n = 1'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_reg_window();
    t_reg_wait(1'h0);
    t_reg_wait(1'h1);
    t_port(1'h0);
    t_port(1'h1);
    t_aen_dma(1'h0);
    t_aen_dma(1'h1);
    t_prom_pass();
    t_line();
    chk1(stuck, 1'h0, "host hang");
    end_of_test();
  end
endmodule : host_io_decode_and_line_sync_glue_tb_top
